// >>> tb/rtcl_core_asserts.sv
// port-level checks for rtcl_core: alarm flag, fail flag, blanking, apb refusals
// assumes it is bound into rtcl_core with the same count parameters
`timescale 1ns/1ps
`default_nettype none
module rtcl_core_asserts #(
  parameter int unsigned LOST_CLK_CYCLES = 5000,
  parameter int unsigned BLANK_CYCLES = 100000
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // oscillator and events
  input wire logic RTC_OSC_IN,
  input wire logic OSC_ENABLE,
  input wire logic ALARM_EVENT,
  input wire logic OSC_FAIL
);
  logic osc_q;
  logic arm_q;
  logic aen_q;
  logic [19:0] stat_q;
  logic [19:0] blank_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_wr_ctl;
    PSEL && PENABLE && PWRITE && PADDR == 8'h10;
  endsequence
  sequence s_rd(a);
    PSEL && PENABLE && !PWRITE && PADDR == a;
  endsequence
  // raw pin quiet time; the design sees edges later, so its count is never ahead
  always_ff @(posedge CLK) begin
    osc_q <= RTC_OSC_IN;
    if (!RSTN || RTC_OSC_IN != osc_q) stat_q <= '0;
    else if (stat_q != '1) stat_q <= stat_q + 1'b1;
    if (!RSTN || !OSC_ENABLE) blank_q <= '0;
    else if (blank_q != '1) blank_q <= blank_q + 1'b1;
    if (!RSTN) begin
      arm_q <= 1'b0;
      aen_q <= 1'b0;
    end else if (PSEL && PENABLE && PWRITE && PADDR == 8'h10) begin
      arm_q <= PWDATA[6];
      aen_q <= PWDATA[3];
    end
  end
  property p_alarm_off_clears;
    s_wr_ctl ##0 !PWDATA[3] |=> ##1 !ALARM_EVENT;
  endproperty
  a_alarm_off_clears: assert property (p_alarm_off_clears)
    else $error("alarm flag outlives alarm disable");
  property p_alarm_short;
    $rose(ALARM_EVENT) |-> ##[1:20] !ALARM_EVENT;
  endproperty
  a_alarm_short: assert property (p_alarm_short)
    else $error("alarm flag held too long");
  property p_fail_quiet;
    $rose(OSC_FAIL) |-> stat_q >= LOST_CLK_CYCLES;
  endproperty
  a_fail_quiet: assert property (p_fail_quiet)
    else $error("fail flag before quiet time");
  property p_fail_armed;
    $rose(OSC_FAIL) |-> arm_q;
  endproperty
  a_fail_armed: assert property (p_fail_armed)
    else $error("fail flag while disarmed");
  property p_blank;
    s_rd(8'h14) ##0 (blank_q < BLANK_CYCLES) |-> !PRDATA[4];
  endproperty
  a_blank: assert property (p_blank)
    else $error("crystal valid seen in blanking");
  property p_alarm_en;
    $rose(ALARM_EVENT) |-> aen_q;
  endproperty
  a_alarm_en: assert property (p_alarm_en)
    else $error("alarm raised while disabled");
  property p_flag_read;
    s_rd(8'h10) |-> PRDATA[2] == $past(ALARM_EVENT);
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("control bit 2 does not read alarm flag");
  property p_unmapped;
    PSEL && PENABLE && !(PADDR inside {8'h10, 8'h14, 8'h20, 8'h24}) |-> PSLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
endmodule : rtcl_core_asserts
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for rtcl_core: apb master, oscillator pin and amplitude pin
// assumes a zero-wait apb slave and shortened lost-clock and blanking counts
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rtcl_pkg::*;
  localparam int unsigned LOST = 50;
  localparam int unsigned BLANK = 100;
  localparam rtcl_addr_t A_CTL = 8'h10;
  localparam rtcl_addr_t A_OSC = 8'h14;
  localparam rtcl_addr_t A_CAP = 8'h20;
  localparam rtcl_addr_t A_MAT = 8'h24;
  logic CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RTC_OSC_IN, XTAL_AMP_OK;
  logic OSC_ENABLE, OSC_AGC_EN, OSC_XMODE, OSC_BIAS_X2, ALARM_EVENT, OSC_FAIL, err;
  rtcl_addr_t PADDR;
  rtcl_word_t PWDATA, PRDATA, rd;
  int fails, checked, cyc;
  rtcl_core #(.LOST_CLK_CYCLES(LOST), .BLANK_CYCLES(BLANK)) dut_u (.CLK, .RSTN, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RTC_OSC_IN,
    .XTAL_AMP_OK, .OSC_ENABLE, .OSC_AGC_EN, .OSC_XMODE, .OSC_BIAS_X2, .ALARM_EVENT,
    .OSC_FAIL);
  task automatic conclude;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input rtcl_word_t got, input rtcl_word_t exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input rtcl_addr_t a, input rtcl_word_t d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  // oscillator half period of 4 clocks keeps the pin slow enough for the synchroniser
  task automatic ticks(input int n);
    repeat (n) begin
      RTC_OSC_IN <= 1'b1;
      repeat (4) @(posedge CLK);
      RTC_OSC_IN <= 1'b0;
      repeat (4) @(posedge CLK);
    end
  endtask : ticks
  task automatic poll(input int b);
    do apb(1'b0, A_CTL, 32'h0); while (rd[b] !== 1'b0);
  endtask : poll
  task automatic snap(input rtcl_word_t ctl, input rtcl_word_t exp);
    apb(1'b1, A_CTL, ctl | 32'h1);
    poll(0);
    apb(1'b0, A_CAP, 32'h0);
    chk(rd, exp);
  endtask : snap
  task automatic t_regs;
    apb(1'b0, A_CTL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, A_OSC, 32'hff);
    apb(1'b0, A_OSC, 32'h0);
    chk(rd, 32'he0);
    chk({OSC_AGC_EN, OSC_XMODE, OSC_BIAS_X2}, 32'h7);
    apb(1'b1, A_OSC, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_count;
    apb(1'b1, A_CAP, 32'hffff_fffe);
    apb(1'b1, A_CTL, 32'h12);
    poll(1);
    ticks(3);
    snap(32'h10, 32'h1);
    apb(1'b1, A_CTL, 32'h0);
    ticks(2);
    snap(32'h0, 32'h1);
    $display("test count done");
  endtask : t_count
  task automatic t_alarm;
    logic seen;
    seen = 1'b0;
    apb(1'b1, A_MAT, 32'h4);
    apb(1'b1, A_CAP, 32'h0);
    apb(1'b1, A_CTL, 32'h1e);
    poll(1);
    for (int k = 1; k <= 9; k++) begin
      ticks(1);
      chk(ALARM_EVENT, k % 5 == 4);
      apb(1'b0, A_CTL, 32'h0);
      chk(rd, (k % 5 == 4) ? 32'h1c : 32'h18);
    end
    apb(1'b1, A_CTL, 32'h14);
    @(posedge CLK);
    #1 chk(ALARM_EVENT, 32'h0);
    apb(1'b1, A_CTL, 32'h16);
    poll(1);
    repeat (6) begin
      ticks(1);
      seen = seen | ALARM_EVENT;
    end
    chk(seen, 32'h0);
    $display("test alarm done");
  endtask : t_alarm
  task automatic t_lost;
    apb(1'b1, A_CTL, 32'h0);
    repeat (2 * LOST) @(posedge CLK);
    chk(OSC_FAIL, 32'h0);
    apb(1'b1, A_CTL, 32'h40);
    ticks(2);
    repeat (LOST / 2) @(posedge CLK);
    chk(OSC_FAIL, 32'h0);
    repeat (LOST) @(posedge CLK);
    chk(OSC_FAIL, 32'h1);
    apb(1'b1, A_CTL, 32'h40);
    repeat (2 * LOST) @(posedge CLK);
    chk(OSC_FAIL, 32'h0);
    apb(1'b1, A_CTL, 32'h0);
    apb(1'b1, A_CTL, 32'h40);
    repeat (2 * LOST) @(posedge CLK);
    chk(OSC_FAIL, 32'h1);
    apb(1'b1, A_CTL, 32'h0);
    $display("test lost clock done");
  endtask : t_lost
  task automatic t_blank;
    XTAL_AMP_OK <= 1'b1;
    apb(1'b1, A_CTL, 32'h80);
    // the write lands at the edge the task returns on; look one edge later
    @(posedge CLK);
    chk(OSC_ENABLE, 32'h1);
    apb(1'b0, A_OSC, 32'h0);
    chk(rd, 32'h0);
    repeat (BLANK) @(posedge CLK);
    apb(1'b0, A_OSC, 32'h0);
    chk(rd, 32'h10);
    $display("test blanking done");
  endtask : t_blank
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  // the whole run needs under a thousand clocks; the ceiling leaves ample margin
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      $display("ERROR t=%0t run timed out", $time);
      conclude();
    end
  end
  initial begin
    RSTN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    RTC_OSC_IN = 1'b0;
    XTAL_AMP_OK = 1'b0;
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    t_regs();
    t_count();
    t_alarm();
    t_lost();
    t_blank();
    conclude();
  end
endmodule : tb
bind rtcl_core rtcl_core_asserts #(.LOST_CLK_CYCLES(LOST_CLK_CYCLES),
  .BLANK_CYCLES(BLANK_CYCLES)) chk_u (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PSLVERR, .RTC_OSC_IN, .OSC_ENABLE, .ALARM_EVENT, .OSC_FAIL);
`default_nettype wire

// >>> verilog/rtcl_core.sv
// rtc timer, alarm, lost-clock detector and crystal-valid gate behind apb
// assumes the oscillator and amplitude detector arrive as async pins
//
// Behaviour
// R1: lost-clock detector armed only while its enable bit is 1; fires once.
// R2: armed detector sets fail flag when oscillator is static over 100 us.
// R3: fail flag is offered as interrupt, wake-up and reset source.
// R4: software disarms the lost-clock detector before changing oscillator settings.
// R5: amplitude detector output reads as bit 4 of oscillator control.
// R6: crystal-valid ignored for 2 ms after the oscillator is switched on.
// R7: software uses the fail flag, not crystal-valid, to spot failure.
// R8: 32-bit timer counts oscillator cycles while run is 1, else holds.
// R9: with auto-reset, timer clears one oscillator cycle after a match.
// R10: writing bit 2 of control sets or clears auto-reset.
// R11: with auto-reset, software programs match as period minus one.
// R12: load and snapshot work while the timer runs.
// R13: load bit copies capture into timer, then hardware clears it.
// R14: snapshot bit copies timer into capture, then hardware clears it.
// R15: alarm event when timer equals the 32-bit match value.
// R16: alarm event is offered as reset, wake-up and interrupt source.
// R17: software disables alarm, writes match, then re-enables alarm.
// R18: clearing alarm-enable clears the alarm event flag.
// R19: re-enabling without auto-reset alarms again only after a wrap.
// R20: alarm flag lasts at most one oscillator cycle per event.
// R21: timer wraps to zero at maximum and keeps counting.
// R22: bit 2 reads alarm flag, writes set auto-reset.
// R23: compare and alarm only while alarm-enable is set.
`timescale 1ns/1ps
`default_nettype none
`include "rtcl_regs.svh"
module rtcl_core
  import rtcl_pkg::*;
#(
  parameter int unsigned LOST_CLK_CYCLES = `RTCL_LOST_CLK_CYCLES,
  parameter int unsigned BLANK_CYCLES = `RTCL_BLANK_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // oscillator pins
  input wire logic RTC_OSC_IN,
  input wire logic XTAL_AMP_OK,
  output logic OSC_ENABLE,
  output logic OSC_AGC_EN,
  output logic OSC_XMODE,
  output logic OSC_BIAS_X2,
  // event sources for interrupt, wake-up and reset logic
  output logic ALARM_EVENT,
  output logic OSC_FAIL
);
  // synchronised pins
  logic osc_s;
  logic amp_s;
  rtcl_sync2 u_sync_osc (
    .clk(CLK),
    .rstn(RSTN),
    .async_in(RTC_OSC_IN),
    .sync_out(osc_s)
  );
  rtcl_sync2 u_sync_amp (
    .clk(CLK),
    .rstn(RSTN),
    .async_in(XTAL_AMP_OK),
    .sync_out(amp_s)
  );

  // control state
  logic osc_en_q, osc_en_d;
  logic lost_clock_detect_en_q, lost_clock_detect_en_d;
  logic osc_fail_flag_q, osc_fail_flag_d;
  logic timer_run_q, timer_run_d;
  logic alarm_enable_q, alarm_enable_d;
  logic autoreset_q, autoreset_d;
  logic timer_load_go_q, timer_load_go_d;
  logic timer_snapshot_go_q, timer_snapshot_go_d;
  logic agc_en_q, agc_en_d;
  logic xmode_q, xmode_d;
  logic bias_x2_q, bias_x2_d;
  rtcl_word_t capture_bytes_q, capture_bytes_d;
  rtcl_word_t match_regs_q, match_regs_d;
  // timer state
  rtcl_word_t timer_q, timer_d;
  logic alarm_flag_autoclear_q, alarm_flag_autoclear_d;
  logic zero_pending_q, zero_pending_d;
  logic osc_prev_q, osc_prev_d;
  logic lost_fired_q, lost_fired_d;
  // bus read data
  rtcl_word_t prdata_q, prdata_d;

  // decode
  logic wr_en;
  logic rd_setup;
  logic hit_ctl, hit_osc, hit_cap, hit_match, mapped;
  logic tick;
  logic edge_seen;
  logic match_hit;
  rtcl_word_t cnt_next;
  logic xtal_amplitude_ok;
  rtcl_byte_t ctl_rd;
  rtcl_byte_t osc_rd;

  rtcl_tmo_if lost_tmo ();
  rtcl_tmo_if blank_tmo ();

  rtcl_timeout #(.LIMIT(LOST_CLK_CYCLES)) u_lost_clk (
    .clk(CLK),
    .rstn(RSTN),
    .tmo(lost_tmo.counter)
  );
  rtcl_timeout #(.LIMIT(BLANK_CYCLES)) u_blank (
    .clk(CLK),
    .rstn(RSTN),
    .tmo(blank_tmo.counter)
  );

  always_comb begin
    hit_ctl = (PADDR == `RTCL_ADDR(`RTCL_IDX_CTL));
    hit_osc = (PADDR == `RTCL_ADDR(`RTCL_IDX_OSC));
    hit_cap = (PADDR == `RTCL_ADDR(`RTCL_IDX_CAPTURE));
    hit_match = (PADDR == `RTCL_ADDR(`RTCL_IDX_MATCH));
    mapped = hit_ctl | hit_osc | hit_cap | hit_match;
    wr_en = PSEL & PENABLE & PWRITE & mapped;
    rd_setup = PSEL & ~PENABLE & ~PWRITE;
  end

  // oscillator edges seen on the system clock
  always_comb begin
    osc_prev_d = osc_s;
    tick = osc_s & ~osc_prev_q;
    edge_seen = osc_s ^ osc_prev_q;
  end

  // lost-clock detector: counts while armed and not yet fired, restarted by any oscillator edge
  always_comb begin
    lost_tmo.run = lost_clock_detect_en_q & ~lost_fired_q; // R1
    lost_tmo.restart = edge_seen; // R2
    lost_fired_d = lost_fired_q;
    if (!lost_clock_detect_en_q) begin
      lost_fired_d = 1'b0; // R1
    end else if (lost_tmo.expired) begin
      lost_fired_d = 1'b1; // R1
    end
  end

  // blanking after the oscillator is switched on
  always_comb begin
    blank_tmo.run = osc_en_q;
    blank_tmo.restart = ~osc_en_q;
    xtal_amplitude_ok = amp_s & blank_tmo.expired; // R6
  end

  // compare the value the timer is about to take, so the flag rises on the
  // tick that reaches the match value and auto-reset gives match plus one counts
  always_comb begin
    cnt_next = zero_pending_q ? `RTCL_WORD_ZERO : timer_q + `RTCL_WORD_ONE; // R9 R21
    match_hit = alarm_enable_q & (cnt_next == match_regs_q); // R15 R23
  end

  // register file next values
  always_comb begin
    osc_en_d = osc_en_q;
    lost_clock_detect_en_d = lost_clock_detect_en_q;
    osc_fail_flag_d = osc_fail_flag_q;
    timer_run_d = timer_run_q;
    alarm_enable_d = alarm_enable_q;
    autoreset_d = autoreset_q;
    timer_load_go_d = 1'b0;
    timer_snapshot_go_d = 1'b0;
    agc_en_d = agc_en_q;
    xmode_d = xmode_q;
    bias_x2_d = bias_x2_q;
    capture_bytes_d = capture_bytes_q;
    match_regs_d = match_regs_q;
    if (wr_en && hit_ctl) begin
      osc_en_d = PWDATA[`RTCL_CTL_OSC_EN];
      lost_clock_detect_en_d = PWDATA[`RTCL_CTL_LOST_CLK_EN];
      osc_fail_flag_d = PWDATA[`RTCL_CTL_FAIL];
      timer_run_d = PWDATA[`RTCL_CTL_RUN];
      alarm_enable_d = PWDATA[`RTCL_CTL_ALARM_EN];
      autoreset_d = PWDATA[`RTCL_CTL_ALARM_FLAG]; // R10 R22
      // go bits only start; hardware clears them after one cycle
      timer_load_go_d = PWDATA[`RTCL_CTL_LOAD_GO]; // R13
      timer_snapshot_go_d = PWDATA[`RTCL_CTL_SNAP_GO]; // R14
    end
    if (wr_en && hit_osc) begin
      agc_en_d = PWDATA[`RTCL_OSC_AGC_EN];
      xmode_d = PWDATA[`RTCL_OSC_XMODE];
      bias_x2_d = PWDATA[`RTCL_OSC_BIAS_X2];
    end
    if (wr_en && hit_cap) begin
      capture_bytes_d = PWDATA;
    end
    if (wr_en && hit_match) begin
      match_regs_d = PWDATA;
    end
    // snapshot does not stop the timer
    if (timer_snapshot_go_q) begin
      capture_bytes_d = timer_q; // R14 R12
    end
    // hardware set beats a software clear in the same cycle
    if (lost_clock_detect_en_q && !lost_fired_q && lost_tmo.expired) begin
      osc_fail_flag_d = 1'b1; // R2
    end
  end

  // timer and alarm next values
  always_comb begin
    timer_d = timer_q;
    zero_pending_d = zero_pending_q;
    alarm_flag_autoclear_d = alarm_flag_autoclear_q;
    if (tick) begin
      // flag lives until the next oscillator tick; a stopped timer raises none
      alarm_flag_autoclear_d = 1'b0; // R20
      if (timer_run_q || zero_pending_q) begin
        alarm_flag_autoclear_d = match_hit; // R15 R20
        zero_pending_d = match_hit & autoreset_q; // R9
      end
    end
    if (!alarm_enable_d) begin
      alarm_flag_autoclear_d = 1'b0; // R18
      zero_pending_d = 1'b0;
    end
    if (timer_load_go_q) begin
      timer_d = capture_bytes_q; // R13 R12
      zero_pending_d = 1'b0;
    end else if (tick && (timer_run_q || zero_pending_q)) begin
      // plain 32-bit add wraps silently; after a re-enable the next hit
      // needs a full lap
      timer_d = cnt_next; // R8 R9 R21 R19
    end
  end

  // read data, sampled in the setup phase so prdata comes from a flop
  always_comb begin
    ctl_rd = {osc_en_q, lost_clock_detect_en_q, osc_fail_flag_q, timer_run_q,
              alarm_enable_q, alarm_flag_autoclear_q, timer_load_go_q,
              timer_snapshot_go_q}; // R22
    osc_rd = {agc_en_q, xmode_q, bias_x2_q, xtal_amplitude_ok, 4'h0}; // R5
    prdata_d = prdata_q;
    if (rd_setup) begin
      prdata_d = `RTCL_WORD_ZERO;
      if (hit_ctl) begin
        prdata_d = {24'h00_0000, ctl_rd};
      end else if (hit_osc) begin
        prdata_d = {24'h00_0000, osc_rd};
      end else if (hit_cap) begin
        prdata_d = capture_bytes_q;
      end else if (hit_match) begin
        prdata_d = match_regs_q;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      osc_en_q <= 1'b0;
      lost_clock_detect_en_q <= 1'b0;
      osc_fail_flag_q <= 1'b0;
      timer_run_q <= 1'b0;
      alarm_enable_q <= 1'b0;
      autoreset_q <= 1'b0;
      timer_load_go_q <= 1'b0;
      timer_snapshot_go_q <= 1'b0;
      agc_en_q <= 1'b0;
      xmode_q <= 1'b0;
      bias_x2_q <= 1'b0;
      capture_bytes_q <= `RTCL_WORD_ZERO;
      match_regs_q <= `RTCL_WORD_ZERO;
      timer_q <= `RTCL_WORD_ZERO;
      alarm_flag_autoclear_q <= 1'b0;
      zero_pending_q <= 1'b0;
      osc_prev_q <= 1'b0;
      lost_fired_q <= 1'b0;
      prdata_q <= `RTCL_WORD_ZERO;
    end else begin
      osc_en_q <= osc_en_d;
      lost_clock_detect_en_q <= lost_clock_detect_en_d;
      osc_fail_flag_q <= osc_fail_flag_d;
      timer_run_q <= timer_run_d;
      alarm_enable_q <= alarm_enable_d;
      autoreset_q <= autoreset_d;
      timer_load_go_q <= timer_load_go_d;
      timer_snapshot_go_q <= timer_snapshot_go_d;
      agc_en_q <= agc_en_d;
      xmode_q <= xmode_d;
      bias_x2_q <= bias_x2_d;
      capture_bytes_q <= capture_bytes_d;
      match_regs_q <= match_regs_d;
      timer_q <= timer_d;
      alarm_flag_autoclear_q <= alarm_flag_autoclear_d;
      zero_pending_q <= zero_pending_d;
      osc_prev_q <= osc_prev_d;
      lost_fired_q <= lost_fired_d;
      prdata_q <= prdata_d;
    end
  end

  // zero wait states; unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA = prdata_q;
  assign OSC_ENABLE = osc_en_q;
  assign OSC_AGC_EN = agc_en_q;
  assign OSC_XMODE = xmode_q;
  assign OSC_BIAS_X2 = bias_x2_q;
  assign ALARM_EVENT = alarm_flag_autoclear_q; // R16
  assign OSC_FAIL = osc_fail_flag_q; // R3
endmodule : rtcl_core
`default_nettype wire

// >>> verilog/rtcl_pkg.sv
// types shared by the rtc timer/alarm modules
// assumes rtcl_regs.svh supplies the numeric constants
package rtcl_pkg;
  typedef logic [31:0] rtcl_word_t;
  typedef logic [7:0] rtcl_addr_t;
  typedef logic [7:0] rtcl_byte_t;
endpackage : rtcl_pkg

// >>> verilog/rtcl_regs.svh
// register offsets, bit positions and timing figures of the rtc block
// assumes a 32-bit apb slave; byte address is four times the register index
`ifndef RTCL_REGS_SVH
`define RTCL_REGS_SVH

`define RTCL_IDX_CTL 6'h04
`define RTCL_IDX_OSC 6'h05
`define RTCL_IDX_CAPTURE 6'h08
`define RTCL_IDX_MATCH 6'h09
`define RTCL_ADDR(idx) ({(idx), 2'b00})

`define RTCL_CTL_OSC_EN 7
`define RTCL_CTL_LOST_CLK_EN 6
`define RTCL_CTL_FAIL 5
`define RTCL_CTL_RUN 4
`define RTCL_CTL_ALARM_EN 3
`define RTCL_CTL_ALARM_FLAG 2
`define RTCL_CTL_LOAD_GO 1
`define RTCL_CTL_SNAP_GO 0

`define RTCL_OSC_AGC_EN 7
`define RTCL_OSC_XMODE 6
`define RTCL_OSC_BIAS_X2 5
`define RTCL_OSC_AMP_OK 4

`define RTCL_CLK_MHZ 50
`define RTCL_LOST_CLK_US 100
`define RTCL_BLANK_US 2000
`define RTCL_LOST_CLK_CYCLES (`RTCL_LOST_CLK_US * `RTCL_CLK_MHZ)
`define RTCL_BLANK_CYCLES (`RTCL_BLANK_US * `RTCL_CLK_MHZ)

`define RTCL_WORD_ZERO 32'h0000_0000
`define RTCL_WORD_ONE 32'h0000_0001

`endif

// >>> verilog/rtcl_sync2.sv
// two flip-flop synchroniser for one asynchronous level
// assumes the input is a pin or another clock's signal
`timescale 1ns/1ps
`default_nettype none
module rtcl_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic sync_q;
  logic meta_d;
  logic sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : rtcl_sync2
`default_nettype wire

// >>> verilog/rtcl_timeout.sv
// saturating cycle counter that flags when LIMIT cycles pass without restart
// assumes run and restart come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module rtcl_timeout #(
  parameter int unsigned LIMIT = 5000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control from the owner
  rtcl_tmo_if.counter tmo
);
  localparam int unsigned CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (tmo.restart || !tmo.run) begin
      count_d = '0;
    end else if (count_q != LIM) begin
      count_d = count_q + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // saturates so the flag stays until restart or stop
  assign tmo.expired = (count_q == LIM);
endmodule : rtcl_timeout
`default_nettype wire

// >>> verilog/rtcl_tmo_if.sv
// interface between the rtc core and one of its timeout counters
// assumes a single clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface rtcl_tmo_if;
  logic run;
  logic restart;
  logic expired;
  modport owner (output run, output restart, input expired);
  modport counter (input run, input restart, output expired);
endinterface : rtcl_tmo_if
`default_nettype wire
